/* File: inc/pcirp_pkg.sv */
`default_nettype none

package pcirp_pkg;

  // capability word, most significant field first
  typedef struct packed {
    logic [2:0] rsvd_hi;
    logic       flr_initiate;
    logic [1:0] slot_power_scale;
    logic [7:0] slot_power_value;
    logic [1:0] rsvd_mid;
    logic       role_error_report_support;
    logic       power_lamp_present;
    logic       attention_lamp_present;
    logic       attention_button_present;
    logic [2:0] l1_exit_latency_tolerance;
    logic [2:0] l0s_exit_latency_tolerance;
    logic       wide_tag_support;
    logic [1:0] borrowed_function_bits;
    logic [2:0] max_payload_support;
  } pcirp_devcap_s;

  // configuration access from the port's config decoder
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [11:0] addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } pcirp_cfg_req_s;

  typedef enum logic [1:0] {
    PCIRP_TLP_OTHER = 2'h0,
    PCIRP_TLP_WRITE = 2'h1,
    PCIRP_TLP_CPLD  = 2'h3
  } pcirp_tlp_kind_e;

  // received packet header summary
  typedef struct packed {
    logic            valid;
    pcirp_tlp_kind_e kind;
    logic [9:0]      len_dw;
  } pcirp_tlp_hdr_s;

  localparam logic [11:0] PCIRP_DEVCAP_OFS   = 12'h070;
  localparam logic [11:0] PCIRP_DW_ADDR_MASK = 12'hFFC;

  localparam int PCIRP_RSVD_HI_LSB  = 29;
  localparam int PCIRP_RSVD_MID_LSB = 16;
  localparam int PCIRP_FLR_BIT   = 28;
  localparam int PCIRP_SCALE_LSB = 26;
  localparam int PCIRP_VALUE_LSB = 18;
  localparam int PCIRP_ROLE_BIT  = 15;
  localparam int PCIRP_PLAMP_BIT = 14;
  localparam int PCIRP_ALAMP_BIT = 13;
  localparam int PCIRP_ABTN_BIT  = 12;
  localparam int PCIRP_L1_LSB    = 9;
  localparam int PCIRP_L0S_LSB   = 6;
  localparam int PCIRP_WTAG_BIT  = 5;
  localparam int PCIRP_BFN_LSB   = 3;
  localparam int PCIRP_MPS_LSB   = 0;

  localparam logic [2:0] PCIRP_MPS_256B = 3'h1;
  localparam int         PCIRP_MAX_PAYLOAD_BYTES = 256;
  localparam int         PCIRP_BYTES_PER_DW = 4;
  localparam logic [10:0] PCIRP_MAX_PAYLOAD_DW =
    11'(PCIRP_MAX_PAYLOAD_BYTES / PCIRP_BYTES_PER_DW);
  // a length field of zero encodes the largest size
  localparam logic [10:0] PCIRP_LEN_ZERO_DW = 11'h400;

  localparam pcirp_devcap_s PCIRP_DEVCAP_RST = '{
    rsvd_hi:                    3'h0,
    flr_initiate:               1'h0,
    slot_power_scale:           2'h0,
    slot_power_value:           8'h00,
    rsvd_mid:                   2'h0,
    role_error_report_support:  1'h1,
    power_lamp_present:         1'h0,
    attention_lamp_present:     1'h0,
    attention_button_present:   1'h0,
    l1_exit_latency_tolerance:  3'h0,
    l0s_exit_latency_tolerance: 3'h0,
    wide_tag_support:           1'h0,
    borrowed_function_bits:     2'h0,
    max_payload_support:        PCIRP_MPS_256B
  };

endpackage : pcirp_pkg

`default_nettype wire

/* File: rtl/pcirp_devcap.sv */
`timescale 1ns/1ps
`default_nettype none

module pcirp_devcap
  import pcirp_pkg::*;
(
  // clock and reset
  input  wire logic           ref_clk,
  input  wire logic           rst_n,
  // configuration access
  input  wire pcirp_cfg_req_s cfg_req,
  output var  logic           cfg_rd_ack_r,
  output var  logic           cfg_wr_ack_r,
  output var  logic [31:0]    cfg_rdata_r,
  // received packet headers
  input  wire pcirp_tlp_hdr_s rx_hdr,
  output var  logic           payload_err_r
);

  function automatic logic addr_hit(input logic [11:0] a);
    addr_hit = (a & PCIRP_DW_ADDR_MASK) == PCIRP_DEVCAP_OFS;
  endfunction : addr_hit

  function automatic logic [10:0] len_to_dw(input logic [9:0] l);
    len_to_dw = (l == 10'h000) ? PCIRP_LEN_ZERO_DW : {1'b0, l};
  endfunction : len_to_dw

  // fixed word held in flops so reset restores it and nothing else does
  pcirp_devcap_s devcap_r;
  pcirp_devcap_s rd_fields;
  logic          rd_hit_r;

  // read word passed field by field so each hard-wired value is visible
  assign rd_fields.rsvd_hi =
    devcap_r.rsvd_hi;
  assign rd_fields.flr_initiate =
    devcap_r.flr_initiate;
  assign rd_fields.slot_power_scale =
    devcap_r.slot_power_scale;
  assign rd_fields.slot_power_value =
    devcap_r.slot_power_value;
  assign rd_fields.rsvd_mid =
    devcap_r.rsvd_mid;
  assign rd_fields.role_error_report_support =
    devcap_r.role_error_report_support;
  assign rd_fields.power_lamp_present =
    devcap_r.power_lamp_present;
  assign rd_fields.attention_lamp_present =
    devcap_r.attention_lamp_present;
  assign rd_fields.attention_button_present =
    devcap_r.attention_button_present;
  assign rd_fields.l1_exit_latency_tolerance =
    devcap_r.l1_exit_latency_tolerance;
  assign rd_fields.l0s_exit_latency_tolerance =
    devcap_r.l0s_exit_latency_tolerance;
  assign rd_fields.wide_tag_support =
    devcap_r.wide_tag_support;
  assign rd_fields.borrowed_function_bits =
    devcap_r.borrowed_function_bits;
  assign rd_fields.max_payload_support =
    devcap_r.max_payload_support;

  wire logic        rd_hit   = cfg_req.rd && addr_hit(cfg_req.addr);
  wire logic        wr_hit   = cfg_req.wr && addr_hit(cfg_req.addr);
  wire logic [31:0] rd_word  = rd_hit ? 32'(rd_fields) : 32'h0000_0000;
  wire logic        has_data = (rx_hdr.kind == PCIRP_TLP_WRITE) ||
                               (rx_hdr.kind == PCIRP_TLP_CPLD);
  wire logic        too_big  = len_to_dw(rx_hdr.len_dw) >
                               PCIRP_MAX_PAYLOAD_DW;
  wire logic        err_nxt  = rx_hdr.valid && has_data && too_big;

  // no write path: writes are acknowledged and dropped
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      devcap_r <= PCIRP_DEVCAP_RST;
    end else begin
      devcap_r <= devcap_r;
    end
  end

  // one-cycle read latency; misses read zero for the outer decoder to merge
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_rd_ack_r <= 1'b0;
      cfg_wr_ack_r <= 1'b0;
      cfg_rdata_r  <= 32'h0000_0000;
      rd_hit_r     <= 1'b0;
    end else begin
      cfg_rd_ack_r <= cfg_req.rd;
      cfg_wr_ack_r <= cfg_req.wr;
      cfg_rdata_r  <= rd_word;
      rd_hit_r     <= rd_hit;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      payload_err_r <= 1'b0;
    end else begin
      payload_err_r <= err_nxt;
    end
  end

  // checks on the returned word, the acknowledges and the error pulse
  wire logic rd_done  = cfg_rd_ack_r && rd_hit_r;
  wire logic hdr_data = rx_hdr.valid && has_data;
  wire logic len_zero = rx_hdr.len_dw == 10'h000;
  wire logic len_over = {1'b0, rx_hdr.len_dw} > PCIRP_MAX_PAYLOAD_DW;

  AST_FLR_ZERO: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    rd_done |-> cfg_rdata_r[PCIRP_FLR_BIT] == 1'b0
  ) else $error("flr initiate bit read as one");

  AST_SCALE_ZERO: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    rd_done |-> cfg_rdata_r[PCIRP_SCALE_LSB +: 2] == 2'h0
  ) else $error("slot power scale nonzero");

  AST_VALUE_ZERO: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    rd_done |-> cfg_rdata_r[PCIRP_VALUE_LSB +: 8] == 8'h00
  ) else $error("slot power value nonzero");

  AST_ROLE_SET: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    rd_done |-> cfg_rdata_r[PCIRP_ROLE_BIT] == 1'b1
  ) else $error("role error reporting not advertised");

  AST_PLAMP_ZERO: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    rd_done |-> !cfg_rdata_r[PCIRP_PLAMP_BIT]
  ) else $error("power indicator reported present");

  AST_ALAMP_ZERO: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    rd_done |-> !cfg_rdata_r[PCIRP_ALAMP_BIT]
  ) else $error("attention indicator reported present");

  AST_ABTN_ZERO: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    rd_done |-> !cfg_rdata_r[PCIRP_ABTN_BIT]
  ) else $error("attention button reported present");

  AST_L1_ZERO: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    rd_done |-> cfg_rdata_r[PCIRP_L1_LSB +: 3] == 3'h0
  ) else $error("l1 latency tolerance nonzero");

  AST_L0S_ZERO: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    rd_done |-> cfg_rdata_r[PCIRP_L0S_LSB +: 3] == 3'h0
  ) else $error("l0s latency tolerance nonzero");

  AST_WTAG_ZERO: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    rd_done |-> !cfg_rdata_r[PCIRP_WTAG_BIT]
  ) else $error("extended tags advertised");

  AST_BFN_ZERO: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    rd_done |-> cfg_rdata_r[PCIRP_BFN_LSB +: 2] == 2'h0
  ) else $error("phantom function bits advertised");

  AST_MPS_256: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    rd_done |-> cfg_rdata_r[PCIRP_MPS_LSB +: 3] == PCIRP_MPS_256B
  ) else $error("max payload code is not 256 bytes");

  AST_ERR_OVER: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (hdr_data && len_over) |=> payload_err_r
  ) else $error("oversize payload not flagged");

  AST_ERR_CAUSE: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    payload_err_r |->
      $past(hdr_data) && ($past(len_zero) || $past(len_over))
  ) else $error("payload error without oversize packet");

  AST_READ_AT_OFS: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (cfg_req.rd && cfg_req.addr == PCIRP_DEVCAP_OFS) |=>
      cfg_rd_ack_r && cfg_rdata_r == 32'h0000_8001
  ) else $error("read at capability offset returned wrong word");

  AST_WRITE_IGN: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    wr_hit |=> cfg_wr_ack_r ##1 (!rd_done ||
      (cfg_rdata_r[PCIRP_RSVD_HI_LSB +: 3] == 3'h0 &&
       cfg_rdata_r[PCIRP_RSVD_MID_LSB +: 2] == 2'h0 &&
       cfg_rdata_r == 32'h0000_8001))
  ) else $error("write altered the capability word");

  AST_RD_ACK: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    cfg_req.rd |=> cfg_rd_ack_r
  ) else $error("read not acknowledged");

  AST_RD_ACK_ONLY: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    !cfg_req.rd |=> !cfg_rd_ack_r
  ) else $error("read acknowledge without a read");

  AST_WR_ACK: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    cfg_req.wr |=> cfg_wr_ack_r
  ) else $error("write not acknowledged");

  AST_WR_ACK_ONLY: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    !cfg_req.wr |=> !cfg_wr_ack_r
  ) else $error("write acknowledge without a write");

  AST_BOTH_ACK: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (cfg_req.rd && cfg_req.wr) |=> cfg_rd_ack_r && cfg_wr_ack_r
  ) else $error("read and write together not both acknowledged");

  AST_MISS_ZERO: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (cfg_req.rd && !rd_hit) |=> cfg_rdata_r == 32'h0000_0000
  ) else $error("read off the register returned data");

  AST_IDLE_ZERO: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    !cfg_req.rd |=> cfg_rdata_r == 32'h0000_0000
  ) else $error("read data present without a read");

  AST_WR_NO_DATA: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (wr_hit && !cfg_req.rd) |=> cfg_rdata_r == 32'h0000_0000
  ) else $error("write to the register returned data");

  AST_RSVD_HI: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    rd_done |-> cfg_rdata_r[PCIRP_RSVD_HI_LSB +: 3] == 3'h0
  ) else $error("upper reserved bits read nonzero");

  AST_RSVD_MID: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    rd_done |-> cfg_rdata_r[PCIRP_RSVD_MID_LSB +: 2] == 2'h0
  ) else $error("middle reserved bits read nonzero");

  AST_WORD_FIXED: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    devcap_r == PCIRP_DEVCAP_RST
  ) else $error("stored capability word drifted");

  AST_HIT_WORD: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    rd_done |-> cfg_rdata_r == 32'h0000_8001
  ) else $error("hit read returned wrong word");

  AST_HIT_ACK: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    rd_hit_r |-> cfg_rd_ack_r
  ) else $error("hit read without acknowledge");

  AST_ERR_KIND: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (rx_hdr.valid && !has_data) |=> !payload_err_r
  ) else $error("payload error on a packet without data");

  AST_ERR_FITS: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (hdr_data && !len_zero && !len_over) |=> !payload_err_r
  ) else $error("payload error on a packet that fits");

  AST_ERR_LEN_ZERO: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (hdr_data && len_zero) |=> payload_err_r
  ) else $error("largest length code not flagged");

  AST_ERR_IDLE: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    !rx_hdr.valid |=> !payload_err_r
  ) else $error("payload error without a header");

  COV_READ:     cover property (@(posedge ref_clk) disable iff (!rst_n)
    rd_done);
  COV_WR_RD:    cover property (@(posedge ref_clk) disable iff (!rst_n)
    wr_hit ##1 rd_hit);
  COV_ERR:      cover property (@(posedge ref_clk) disable iff (!rst_n)
    payload_err_r);
  COV_LEN_ZERO: cover property (@(posedge ref_clk) disable iff (!rst_n)
    hdr_data && len_zero);
  COV_RD_WR:    cover property (@(posedge ref_clk) disable iff (!rst_n)
    cfg_req.rd && cfg_req.wr);

endmodule : pcirp_devcap

`default_nettype wire

/* File: testbench/pcirp_devcap_test.sv */
`timescale 1ns/1ps
`default_nettype none

module pcirp_devcap_test;
  import pcirp_pkg::*;

  logic           ref_clk;
  logic           rst_n;
  pcirp_cfg_req_s cfg_req;
  pcirp_tlp_hdr_s rx_hdr;
  logic           cfg_rd_ack_r;
  logic           cfg_wr_ack_r;
  logic [31:0]    cfg_rdata_r;
  logic           payload_err_r;
  int             n_errors;
  int             checks_done;
  int             seed;
  int             r;
  logic [34:0]    exp_q[$];
  logic [34:0]    e;
  logic [9:0]     lens[6] = '{10'h000, 10'h001, 10'h03F, 10'h040,
                              10'h041, 10'h3FF};

  pcirp_devcap i_pcirp_devcap (
    .ref_clk       (ref_clk),
    .rst_n         (rst_n),
    .cfg_req       (cfg_req),
    .cfg_rd_ack_r  (cfg_rd_ack_r),
    .cfg_wr_ack_r  (cfg_wr_ack_r),
    .cfg_rdata_r   (cfg_rdata_r),
    .rx_hdr        (rx_hdr),
    .payload_err_r (payload_err_r)
  );

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // capability word built bit by bit; every unnamed bit stays zero
  function automatic logic [31:0] devcap_word();
    integer w;
    w = 0;
    w = w | (1 << 15);
    w = w | 1;
    return w[31:0];
  endfunction : devcap_word

  // expected {rd_ack, wr_ack, err, rdata} one cycle after the inputs
  function automatic logic [34:0] model(pcirp_cfg_req_s q,
                                        pcirp_tlp_hdr_s h);
    integer len;
    logic   big;
    logic   hit;
    len = (h.len_dw == 10'h000) ? 1024 : int'(h.len_dw);
    big = h.valid && (h.kind == 1 || h.kind == 3) && (len * 4 > 256);
    hit = q.rd && (q.addr[11:2] == 10'h01C);
    return {q.rd, q.wr, big, hit ? devcap_word() : 32'h0000_0000};
  endfunction : model

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic final_report();
    $display("errors=%0d checks=%0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : final_report

  // random traffic, biased towards the register and the 64-dword edge
  task automatic drive();
    r = $random(seed);
    cfg_req.rd    = r[0];
    cfg_req.wr    = r[1];
    cfg_req.addr  = r[2] ? {10'h01C, r[4:3]} : r[15:4];
    cfg_req.be    = r[19:16];
    cfg_req.wdata = $random(seed);
    rx_hdr.valid  = r[20];
    rx_hdr.kind   = pcirp_tlp_kind_e'(r[22:21]);
    rx_hdr.len_dw = r[23] ? lens[r[26:24] % 6] : r[31:22];
  endtask : drive

  initial begin
    #(5ns * 5000);
    n_errors++;
    final_report();
  end

  initial begin
    seed = 71002;
    n_errors = 0;
    checks_done = 0;
    rst_n = 1'b0;
    cfg_req = '0;
    rx_hdr = '0;
    repeat (16) @(negedge ref_clk);
    rst_n = 1'b1;
    for (int i = 0; i < 3000; i++) begin
      @(negedge ref_clk);
      if (exp_q.size() > 0) begin
        e = exp_q.pop_front();
        check({29'h0, cfg_rd_ack_r, cfg_wr_ack_r, payload_err_r},
              {29'h0, e[34:32]});
        check(cfg_rdata_r, e[31:0]);
        check(32'(cfg_rdata_r[28:18]), 32'(e[28:18]));
        check(32'(cfg_rdata_r[15:13]), 32'(e[15:13]));
        check(32'(cfg_rdata_r[12:6]), 32'(e[12:6]));
        check(32'(cfg_rdata_r[5:0]), 32'(e[5:0]));
      end
      if (i == 1500) begin
        rst_n = 1'b0;
        exp_q.delete();
        @(negedge ref_clk);
        check({cfg_rd_ack_r, cfg_wr_ack_r, payload_err_r, cfg_rdata_r[28:0]},
              32'h0000_0000);
        rst_n = 1'b1;
      end
      drive();
      exp_q.push_back(model(cfg_req, rx_hdr));
    end
    final_report();
  end

endmodule : pcirp_devcap_test

`default_nettype wire
